/* design/pcdaf_pkg.sv */
package pcdaf_pkg;

	// pin slots: port c pins 0..7, then port d pins 6 and 7
	localparam int   PC_W    = 8;
	localparam int   PD_W    = 2;
	localparam int   NPIN    = 10;
	localparam int   PIN_C0  = 0;
	localparam int   PIN_C1  = 1;
	localparam int   PIN_C2  = 2;
	localparam int   PIN_C3  = 3;
	localparam int   PIN_C4  = 4;
	localparam int   PIN_C5  = 5;
	localparam int   PIN_C6  = 6;
	localparam int   PIN_C7  = 7;
	localparam int   PIN_D6  = 8;
	localparam int   PIN_D7  = 9;

	// pin-change source numbers carried by the pins
	localparam int   PINCHG_C_BASE = 16;
	localparam int   PINCHG_D6     = 30;
	localparam int   PINCHG_D7     = 31;

	// constant override values
	localparam logic BIT_LO  = 1'b0;
	localparam logic BIT_HI  = 1'b1;

	typedef struct packed {
		logic [NPIN-1:0] pad_out;
		logic [NPIN-1:0] pad_oe;
		logic [NPIN-1:0] pad_pu;
		logic [NPIN-1:0] pad_den;
		logic            twi_sda;
		logic            twi_scl;
		logic            tdi;
		logic            tms;
		logic            tck;
		logic            osc_in;
		logic            osc_link;
		logic            t1_cap;
		logic [PC_W-1:0] pc_src;
		logic [PD_W-1:0] pd_src;
	} pcdaf_state_type;

endpackage

/* design/pcdaf_pin_resolve.sv */
`timescale 1ns/1ps
module pcdaf_pin_resolve (
	input  wire logic port_val_i,
	input  wire logic port_dir_i,
	input  wire logic pullup_disable_i,
	input  wire logic sleep_i,
	input  wire logic pullup_override_en_i,
	input  wire logic pullup_override_val_i,
	input  wire logic dir_override_en_i,
	input  wire logic dir_override_val_i,
	input  wire logic outval_override_en_i,
	input  wire logic outval_override_val_i,
	input  wire logic din_en_override_en_i,
	input  wire logic din_en_override_val_i,
	input  wire logic pad_i,
	output logic      drive_o,
	output logic      oe_o,
	output logic      pu_o,
	output logic      den_o,
	output logic      din_o
);
	logic normal_pu;

	assign normal_pu = ~port_dir_i & port_val_i & ~pullup_disable_i;
	assign pu_o    = pullup_override_en_i ? pullup_override_val_i : normal_pu;
	assign oe_o    = dir_override_en_i ? dir_override_val_i : port_dir_i;
	assign drive_o = outval_override_en_i ? outval_override_val_i
	                                      : port_val_i;
	assign den_o   = din_en_override_en_i ? din_en_override_val_i : ~sleep_i;
	assign din_o   = den_o & pad_i;
endmodule

/* design/pcdaf_top.sv */
`timescale 1ns/1ps
//Contract
// - twi enable overrides pins c1 c0
// - pins c1 c0 feed twi inputs
// - tap enable overrides c5..c2, inputs forced
// - async timer overrides pin c6 oscillator
// - pin c1 pin-change source 17
// - pin c0 pin-change source 16
// - pin d7 drives timer2 compare a
// - pin d6 drives timer2 compare b
// - pin d6 feeds timer1 capture
// - pins d7 d6 pin-change 31 30
// - pull-up disable kills normal pull-ups
module pcdaf_top
	import pcdaf_pkg::*;
(
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_i,
	input  wire logic [pcdaf_pkg::PC_W-1:0] portc_val_i,
	input  wire logic [pcdaf_pkg::PC_W-1:0] portc_dir_i,
	input  wire logic [pcdaf_pkg::PC_W-1:0] portc_pad_i,
	input  wire logic                       portd_val_bit7_i,
	input  wire logic                       portd_val_bit6_i,
	input  wire logic                       portd_dir_bit7_i,
	input  wire logic                       portd_dir_bit6_i,
	input  wire logic                       portd_pad_bit7_i,
	input  wire logic                       portd_pad_bit6_i,
	input  wire logic                       pullup_disable_i,
	input  wire logic                       sleep_i,
	input  wire logic                       twowire_enable_i,
	input  wire logic                       twowire_sda_out_i,
	input  wire logic                       twowire_scl_out_i,
	input  wire logic                       tap_enable_i,
	input  wire logic                       tap_shift_instr_i,
	input  wire logic                       tap_shift_datareg_i,
	input  wire logic                       tap_tdo_i,
	input  wire logic                       timer2_async_sel_i,
	input  wire logic                       timer2_ext_clock_sel_i,
	input  wire logic                       t2_compare_a_en_i,
	input  wire logic                       t2_compare_a_out_i,
	input  wire logic                       t2_compare_b_en_i,
	input  wire logic                       t2_compare_b_out_i,
	input  wire logic                       pinchg_group_c_en_i,
	input  wire logic                       pinchg_group_d_en_i,
	input  wire logic [pcdaf_pkg::PC_W-1:0] pinchg_mask_c_i,
	input  wire logic [pcdaf_pkg::PD_W-1:0] pinchg_mask_d_i,
	output logic [pcdaf_pkg::PC_W-1:0]      portc_pad_o,
	output logic [pcdaf_pkg::PC_W-1:0]      portc_pad_oe_o,
	output logic [pcdaf_pkg::PC_W-1:0]      portc_pullup_o,
	output logic [pcdaf_pkg::PC_W-1:0]      portc_din_en_o,
	output logic [pcdaf_pkg::PD_W-1:0]      portd_pad_o,
	output logic [pcdaf_pkg::PD_W-1:0]      portd_pad_oe_o,
	output logic [pcdaf_pkg::PD_W-1:0]      portd_pullup_o,
	output logic [pcdaf_pkg::PD_W-1:0]      portd_din_en_o,
	output logic                            twowire_sda_in_o,
	output logic                            twowire_scl_in_o,
	output logic                            tap_tdi_o,
	output logic                            tap_tms_o,
	output logic                            tap_tck_o,
	output logic                            timer_osc_in_o,
	output logic                            timer_osc_out_o,
	output logic                            t1_capture_in_o,
	output logic [pcdaf_pkg::PC_W-1:0]      pinchg_src_c_o,
	output logic [pcdaf_pkg::PD_W-1:0]      pinchg_src_d_o
);
	import pcdaf_pkg::*;

	logic [NPIN-1:0] pullup_override_en;
	logic [NPIN-1:0] pullup_override_val;
	logic [NPIN-1:0] dir_override_en;
	logic [NPIN-1:0] dir_override_val;
	logic [NPIN-1:0] outval_override_en;
	logic [NPIN-1:0] outval_override_val;
	logic [NPIN-1:0] din_en_override_en;
	logic [NPIN-1:0] din_en_override_val;
	logic [NPIN-1:0] port_val;
	logic [NPIN-1:0] port_dir;
	logic [NPIN-1:0] pad_in;
	logic [NPIN-1:0] drive;
	logic [NPIN-1:0] oe;
	logic [NPIN-1:0] pu;
	logic [NPIN-1:0] den;
	logic [NPIN-1:0] din;
	logic [PC_W-1:0] pcm_c;
	logic [PD_W-1:0] pcm_d;
	logic            tw;
	logic            jt;
	logic            as2;
	logic            xclk;
	logic            xtal;
	pcdaf_state_type st_r;
	pcdaf_state_type st_nxt;

	assign tw   = twowire_enable_i;
	assign jt   = tap_enable_i;
	assign as2  = timer2_async_sel_i;
	assign xclk = timer2_ext_clock_sel_i;
	assign xtal = as2 & ~xclk;

	assign port_val = {portd_val_bit7_i, portd_val_bit6_i, portc_val_i};
	assign port_dir = {portd_dir_bit7_i, portd_dir_bit6_i, portc_dir_i};
	assign pad_in   = {portd_pad_bit7_i, portd_pad_bit6_i, portc_pad_i};

	assign pcm_c = pinchg_mask_c_i & {PC_W{pinchg_group_c_en_i}};
	assign pcm_d = pinchg_mask_d_i & {PD_W{pinchg_group_d_en_i}};

	assign pullup_override_en = {BIT_LO, BIT_LO, xtal, as2,
	                             jt, jt, jt, jt, tw, tw};
	assign pullup_override_val = {BIT_LO, BIT_LO, BIT_LO, BIT_LO,
	                              BIT_HI, BIT_HI, BIT_HI, BIT_HI,
	                              portc_val_i[PIN_C1] & ~pullup_disable_i,
	                              portc_val_i[PIN_C0] & ~pullup_disable_i};
	assign dir_override_en = {BIT_LO, BIT_LO, xtal, as2,
	                          jt, jt, jt, jt, tw, tw};
	assign dir_override_val = {BIT_LO, BIT_LO, BIT_LO, BIT_LO, BIT_LO,
	                           tap_shift_instr_i | tap_shift_datareg_i,
	                           BIT_LO, BIT_LO, BIT_LO, BIT_LO};
	assign outval_override_en = {t2_compare_a_en_i, t2_compare_b_en_i,
	                             BIT_LO, BIT_LO, BIT_LO, jt,
	                             BIT_LO, BIT_LO, tw, tw};
	assign outval_override_val = {t2_compare_a_out_i, t2_compare_b_out_i,
	                              BIT_LO, BIT_LO, BIT_LO, tap_tdo_i,
	                              BIT_LO, BIT_LO,
	                              twowire_sda_out_i, twowire_scl_out_i};
	assign din_en_override_en = {pcm_d[PIN_D7-PIN_D6], pcm_d[0],
	                             (as2 & xclk) | pcm_c[PIN_C7],
	                             as2 | pcm_c[PIN_C6],
	                             jt | pcm_c[PIN_C5], jt | pcm_c[PIN_C4],
	                             jt | pcm_c[PIN_C3], jt | pcm_c[PIN_C2],
	                             pcm_c[PIN_C1], pcm_c[PIN_C0]};
	assign din_en_override_val = {BIT_HI, BIT_HI, as2, xclk | as2,
	                              jt, jt, jt, jt, BIT_HI, BIT_HI};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_pin
			pcdaf_pin_resolve u_res (
				.port_val_i            (port_val[gi]),
				.port_dir_i            (port_dir[gi]),
				.pullup_disable_i      (pullup_disable_i),
				.sleep_i               (sleep_i),
				.pullup_override_en_i  (pullup_override_en[gi]),
				.pullup_override_val_i (pullup_override_val[gi]),
				.dir_override_en_i     (dir_override_en[gi]),
				.dir_override_val_i    (dir_override_val[gi]),
				.outval_override_en_i  (outval_override_en[gi]),
				.outval_override_val_i (outval_override_val[gi]),
				.din_en_override_en_i  (din_en_override_en[gi]),
				.din_en_override_val_i (din_en_override_val[gi]),
				.pad_i                 (pad_in[gi]),
				.drive_o               (drive[gi]),
				.oe_o                  (oe[gi]),
				.pu_o                  (pu[gi]),
				.den_o                 (den[gi]),
				.din_o                 (din[gi])
			);
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		st_nxt.pad_out = drive;
		st_nxt.pad_oe  = oe;
		st_nxt.pad_pu  = pu;
		st_nxt.pad_den = den;
		st_nxt.twi_sda = pad_in[PIN_C1];
		st_nxt.twi_scl = pad_in[PIN_C0];
		st_nxt.tdi = jt & pad_in[PIN_C5];
		st_nxt.tms = jt & pad_in[PIN_C3];
		st_nxt.tck = jt & pad_in[PIN_C2];
		st_nxt.osc_in = as2 & pad_in[PIN_C6];
		st_nxt.osc_link = xtal;
		st_nxt.t1_cap = din[PIN_D6];
		st_nxt.pc_src = din[PIN_C7:PIN_C0];
		st_nxt.pd_src = din[PIN_D7:PIN_D6];
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign portc_pad_o      = st_r.pad_out[PIN_C7:PIN_C0];
	assign portc_pad_oe_o   = st_r.pad_oe[PIN_C7:PIN_C0];
	assign portc_pullup_o   = st_r.pad_pu[PIN_C7:PIN_C0];
	assign portc_din_en_o   = st_r.pad_den[PIN_C7:PIN_C0];
	assign portd_pad_o      = st_r.pad_out[PIN_D7:PIN_D6];
	assign portd_pad_oe_o   = st_r.pad_oe[PIN_D7:PIN_D6];
	assign portd_pullup_o   = st_r.pad_pu[PIN_D7:PIN_D6];
	assign portd_din_en_o   = st_r.pad_den[PIN_D7:PIN_D6];
	assign twowire_sda_in_o = st_r.twi_sda;
	assign twowire_scl_in_o = st_r.twi_scl;
	assign tap_tdi_o        = st_r.tdi;
	assign tap_tms_o        = st_r.tms;
	assign tap_tck_o        = st_r.tck;
	assign timer_osc_in_o   = st_r.osc_in;
	assign timer_osc_out_o  = st_r.osc_link;
	assign t1_capture_in_o  = st_r.t1_cap;
	assign pinchg_src_c_o   = st_r.pc_src;
	assign pinchg_src_d_o   = st_r.pd_src;
endmodule

/* verif/pcdaf_checker.sv */
`timescale 1ns/1ps
module pcdaf_checker (
	input wire logic       sys_clk_i, rst_i, tap_enable_i, tap_tdo_i,
	input wire logic       tap_shift_instr_i, tap_shift_datareg_i,
	input wire logic       twowire_enable_i, twowire_sda_out_i,
	input wire logic       twowire_scl_out_i, timer2_async_sel_i,
	input wire logic       timer2_ext_clock_sel_i, timer_osc_out_o,
	input wire logic       pinchg_group_c_en_i, t2_compare_a_en_i,
	input wire logic       t2_compare_a_out_i, twowire_sda_in_o,
	input wire logic       twowire_scl_in_o, tap_tdi_o, timer_osc_in_o,
	input wire logic [7:0] portc_pad_i, pinchg_mask_c_i, portc_pad_o,
	input wire logic [7:0] portc_pad_oe_o, portc_pullup_o, portc_din_en_o,
	input wire logic [7:0] pinchg_src_c_o,
	input wire logic [1:0] portd_pad_o
);
	logic live_r;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge sys_clk_i) begin
		live_r <= !rst_i;
	end
	sequence s_tw; live_r && $past(twowire_enable_i); endsequence
	sequence s_jt; live_r && $past(tap_enable_i); endsequence
	sequence s_as; live_r && $past(timer2_async_sel_i); endsequence
	sequence s_xt;
		live_r && $past(timer2_async_sel_i && !timer2_ext_clock_sel_i);
	endsequence
	AST_TWI_OVR: assert property (s_tw |-> portc_pad_oe_o[1:0] == 2'b00 &&
		portc_pad_o[1:0] == {$past(twowire_sda_out_i), $past(twowire_scl_out_i)})
		else $error("two-wire pin override wrong");
	AST_TWI_IN: assert property (live_r |->
		{twowire_sda_in_o, twowire_scl_in_o} == $past(portc_pad_i[1:0]))
		else $error("two-wire inputs wrong");
	AST_TAP_OVR: assert property (s_jt |-> portc_pullup_o[5:2] == 4'hf &&
		!portc_pad_oe_o[5] && portc_pad_oe_o[3:2] == 2'b00)
		else $error("tap pin override wrong");
	AST_TAP_TDO: assert property (s_jt |-> portc_pad_o[4] == $past(tap_tdo_i) &&
		portc_pad_oe_o[4] == $past(tap_shift_instr_i || tap_shift_datareg_i))
		else $error("tap data out wrong");
	AST_TAP_DIN: assert property (s_jt |-> portc_din_en_o[5:2] == 4'hf &&
		tap_tdi_o == $past(portc_pad_i[5]))
		else $error("tap input routing wrong");
	AST_OSC: assert property (s_as |-> !portc_pullup_o[6] &&
		!portc_pad_oe_o[6] && portc_din_en_o[6] &&
		timer_osc_in_o == $past(portc_pad_i[6]))
		else $error("oscillator input pin wrong");
	AST_OSC_OUT: assert property (s_xt |-> timer_osc_out_o &&
		!portc_pullup_o[7] && !portc_pad_oe_o[7])
		else $error("oscillator output pin wrong");
	AST_PCHG: assert property (live_r &&
		$past(pinchg_group_c_en_i && pinchg_mask_c_i[1]) |->
		portc_din_en_o[1] && pinchg_src_c_o[1] == $past(portc_pad_i[1]))
		else $error("pin-change source wrong");
	AST_CMP_A: assert property (live_r && $past(t2_compare_a_en_i) |->
		portd_pad_o[1] == $past(t2_compare_a_out_i))
		else $error("compare a output wrong");
endmodule
bind pcdaf_top pcdaf_checker u_chk (.*);

/* verif/pcdaf_periph_model.sv */
`timescale 1ns/1ps
module pcdaf_periph_model (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] duty_i,
	output logic            sda_o,
	output logic            scl_o,
	output logic            tdo_o,
	output logic            cmp_a_o,
	output logic            cmp_b_o
);
	logic [3:0] cnt_r;
	always_ff @(posedge sys_clk_i) begin
		cnt_r <= rst_i ? 4'h0 : cnt_r + 4'h1;
	end
	assign scl_o = cnt_r[1];
	assign sda_o = cnt_r[2] ^ cnt_r[0];
	assign tdo_o = cnt_r[3] ^ cnt_r[0];
	assign cmp_a_o = cnt_r < duty_i;
	assign cmp_b_o = cnt_r >= duty_i;
endmodule

/* verif/port_c_d_alt_function_override_test.sv */
`timescale 1ns/1ps
module port_c_d_alt_function_override_test;
	logic       sys_clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic [7:0] portc_val_i, portc_dir_i, portc_pad_i, pinchg_mask_c_i;
	logic [1:0] pinchg_mask_d_i;
	logic [3:0] duty;
	logic       portd_val_bit7_i, portd_val_bit6_i, portd_dir_bit7_i;
	logic       portd_dir_bit6_i, portd_pad_bit7_i, portd_pad_bit6_i;
	logic       pullup_disable_i, sleep_i, twowire_enable_i, tap_enable_i;
	logic       tap_shift_instr_i, tap_shift_datareg_i, timer2_async_sel_i;
	logic       timer2_ext_clock_sel_i, t2_compare_a_en_i, t2_compare_b_en_i;
	logic       pinchg_group_c_en_i, pinchg_group_d_en_i;
	wire        twowire_sda_out_i, twowire_scl_out_i, tap_tdo_i;
	wire        t2_compare_a_out_i, t2_compare_b_out_i;
	wire [7:0]  portc_pad_o, portc_pad_oe_o, portc_pullup_o, portc_din_en_o;
	wire [7:0]  pinchg_src_c_o;
	wire [1:0]  portd_pad_o, portd_pad_oe_o, portd_pullup_o, portd_din_en_o;
	wire [1:0]  pinchg_src_d_o;
	wire        twowire_sda_in_o, twowire_scl_in_o, tap_tdi_o, tap_tms_o;
	wire        tap_tck_o, timer_osc_in_o, timer_osc_out_o, t1_capture_in_o;
	wire [57:0] got = {portc_pad_o, portc_pad_oe_o, portc_pullup_o,
		portc_din_en_o, portd_pad_o, portd_pad_oe_o, portd_pullup_o,
		portd_din_en_o, twowire_sda_in_o, twowire_scl_in_o, tap_tdi_o,
		tap_tms_o, tap_tck_o, timer_osc_in_o, timer_osc_out_o,
		t1_capture_in_o, pinchg_src_c_o, pinchg_src_d_o};
	logic [57:0] q [$];
	logic [31:0] seed = 32'hf822;
	int          err_count = 0;
	int          checks = 0;

	pcdaf_top u_dut (.*);
	pcdaf_periph_model u_periph (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.duty_i(duty), .sda_o(twowire_sda_out_i), .scl_o(twowire_scl_out_i),
		.tdo_o(tap_tdo_i), .cmp_a_o(t2_compare_a_out_i),
		.cmp_b_o(t2_compare_b_out_i));

	always #20 sys_clk_i = ~sys_clk_i;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [4:0] pin(input logic [7:0] ov,
		input logic v, input logic d, input logic p);
		logic den;
		den = ov[1] ? ov[0] : !sleep_i;
		return {ov[3] ? ov[2] : v, ov[5] ? ov[4] : d,
			ov[7] ? ov[6] : (!d & v & !pullup_disable_i), den, p & den};
	endfunction

	function automatic logic [57:0] expv();
		logic [9:0] o, e, u, d, i;
		logic [7:0] ov;
		logic       jt, as, ex, tw, pc, pd;
		jt = tap_enable_i;
		as = timer2_async_sel_i;
		ex = timer2_ext_clock_sel_i;
		tw = twowire_enable_i;
		pd = pinchg_group_d_en_i;
		for (int n = 0; n < 8; n++) begin
			pc = pinchg_mask_c_i[n] & pinchg_group_c_en_i;
			case (n)
			7: ov = {as & !ex, 1'b0, as & !ex, 3'b000, (as & ex) | pc, as};
			6: ov = {as, 1'b0, as, 3'b000, as | pc, ex | as};
			4: ov = {jt, 1'b1, jt, tap_shift_instr_i | tap_shift_datareg_i,
				jt, tap_tdo_i, jt | pc, jt};
			1, 0: ov = {tw, portc_val_i[n] & !pullup_disable_i, tw, 1'b0, tw,
				n[0] ? twowire_sda_out_i : twowire_scl_out_i, pc, 1'b1};
			default: ov = {jt, 1'b1, jt, 3'b000, jt | pc, jt};
			endcase
			{o[n], e[n], u[n], d[n], i[n]} = pin(ov, portc_val_i[n],
				portc_dir_i[n], portc_pad_i[n]);
		end
		{o[9], e[9], u[9], d[9], i[9]} = pin({4'h0, t2_compare_a_en_i,
			t2_compare_a_out_i, pinchg_mask_d_i[1] & pd, 1'b1},
			portd_val_bit7_i, portd_dir_bit7_i, portd_pad_bit7_i);
		{o[8], e[8], u[8], d[8], i[8]} = pin({4'h0, t2_compare_b_en_i,
			t2_compare_b_out_i, pinchg_mask_d_i[0] & pd, 1'b1},
			portd_val_bit6_i, portd_dir_bit6_i, portd_pad_bit6_i);
		return rst_i ? '0 : {o[7:0], e[7:0], u[7:0], d[7:0], o[9:8], e[9:8],
			u[9:8], d[9:8], portc_pad_i[1:0], portc_pad_i[5] & jt,
			portc_pad_i[3] & jt, portc_pad_i[2] & jt, portc_pad_i[6] & as,
			as & !ex, i[8], i[7:0], i[9:8]};
	endfunction

	task automatic step();
		logic [31:0] a, b;
		a = xs();
		b = xs();
		q.push_back(expv());
		{portc_val_i, portc_dir_i, portc_pad_i, pinchg_mask_c_i} <= a;
		{portd_val_bit7_i, portd_val_bit6_i, portd_dir_bit7_i, portd_dir_bit6_i,
			portd_pad_bit7_i, portd_pad_bit6_i, pullup_disable_i, sleep_i,
			twowire_enable_i, tap_enable_i, tap_shift_instr_i,
			tap_shift_datareg_i, timer2_async_sel_i, timer2_ext_clock_sel_i,
			t2_compare_a_en_i, t2_compare_b_en_i, pinchg_group_c_en_i,
			pinchg_group_d_en_i, pinchg_mask_d_i, duty} <= b[23:0];
	endtask

	task automatic run(input int n, input logic r, input int id);
		repeat (n) begin
			@(posedge sys_clk_i);
			step();
			rst_i <= r;
		end
		$display("test %0d done", id);
	endtask

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	always @(negedge sys_clk_i) begin
		logic [57:0] x;
		if (q.size() > 0) begin
			x = q.pop_front();
			checks++;
			if (got !== x) begin
				err_count++;
				$display("BAD t=%0t exp=%h got=%h", $time, x, got);
			end
		end
	end

	initial begin
		step();
		q.delete();
		run(3, 1'b1, 0);
		run(3000, 1'b0, 1);
		run(4, 1'b1, 2);
		run(1000, 1'b0, 3);
		// let the last note be popped before the verdict
		repeat (2) @(posedge sys_clk_i);
		if (q.size() != 0) err_count++;
		finish_test();
	end

	initial begin
		#(6000 * 40);
		err_count++;
		finish_test();
	end
endmodule
